//--- include/cell_balance_pkg.sv
// Shared constants and carrier types for the passive cell balancing block
package cell_balance_pkg;

  // Channel and field widths
  localparam int NUM_CHAN = 16;
  localparam int TIMER_W = 8;
  localparam int DUTY_W = 3;
  localparam int COUNT_W = 4;
  localparam int NUM_DIE_SENS = 4;

  // Manual mode limits
  localparam logic [4:0] MAX_MANUAL_ON = 5'h08;
  localparam logic [4:0] MAX_RUN_NEIGHBORS = 5'h02;
  localparam logic [4:0] MAX_RUN_ISOLATED = 5'h01;

  // Timer unit: one timer count is this long
  localparam int CLK_HZ = 25_000_000;
  localparam int TIMER_UNIT_MS = 1000;
  localparam int TIMER_UNIT_CYCLES = (CLK_HZ / 1000) * TIMER_UNIT_MS;

  // Reset values
  localparam logic [NUM_CHAN-1:0] SWITCH_RST = 16'h0000;
  localparam logic [TIMER_W-1:0] TIMER_RST = 8'h00;
  localparam logic [DUTY_W-1:0] PHASE_RST = 3'h0;

  // Balancing sequencer states, Gray coded along idle, run, pause
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_RUN = 2'h1,
    ST_PAUSE = 2'h3
  } bal_state_t;

  // Host configuration bits
  typedef struct packed {
    logic auto_alternate_select;
    logic [DUTY_W-1:0] alternate_duty_field;
    logic forbid_neighbor_switches;
    logic [COUNT_W-1:0] active_channel_count;
    logic thermistor_pause_enable;
    logic fault_abort_enable;
  } bal_cfg_t;

  // Status flags shown to the host
  typedef struct packed {
    logic balance_running_flag;
    logic paused_flag;
    logic overtemp_pause_flag;
    logic bad_config_flag;
    logic fault_abort_flag;
  } bal_status_t;

  localparam bal_status_t STATUS_RST = 5'h00;

endpackage : cell_balance_pkg

//--- verif/cell_bank_model.sv
// Model of the cells, die sensors and thermistor protector behind the switches
`timescale 1ns/10ps
module cell_bank_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [15:0] i_balance_switch,
  input wire logic i_die_hot,
  input wire logic i_therm_hot,
  output logic [3:0] o_die_over,
  output logic [3:0] o_die_below,
  output logic o_therm_over,
  output logic o_therm_cooled
);
  // Die heats only while a switch conducts; sensor 0 sits by the hot spot
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_die_over <= 4'h0;
      o_die_below <= 4'hF;
    end
    else
    begin
      o_die_over <= {3'h0, i_die_hot & (|i_balance_switch)};
      o_die_below <= {3'h7, ~i_die_hot};
    end
  end

  // Protector verdict on thermistors against threshold and recovery level
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_therm_over <= 1'b0;
      o_therm_cooled <= 1'b1;
    end
    else
    begin
      o_therm_over <= i_therm_hot;
      o_therm_cooled <= ~i_therm_hot;
    end
  end
endmodule : cell_bank_model

//--- verif/passive_cell_balance_control_bench.sv
// Self-checking bench for the passive cell balancing controller
`timescale 1ns/10ps
module passive_cell_balance_control_bench;
  logic i_clk;
  logic i_rst_n;
  logic go;
  cell_balance_pkg::bal_cfg_t cfg;
  logic [15:0][7:0] tmr;
  logic host_pause;
  logic fault;
  logic die_hot;
  logic therm_hot;
  logic [3:0] die_over;
  logic [3:0] die_below;
  logic therm_over;
  logic therm_cool;
  logic [15:0] sw;
  logic sens_en;
  cell_balance_pkg::bal_status_t st;
  int error_cnt;
  int compares;

  cell_balance_ctrl #(.TICK_CYCLES(4), .NUM_DIE_SENS(4)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_balance_go_cmd(go), .i_cfg(cfg),
    .i_channel_timer_setting(tmr), .i_host_pause_request(host_pause),
    .i_unmasked_fault(fault), .i_die_over_threshold(die_over),
    .i_die_below_release(die_below), .i_thermistor_overtemp_pause(therm_over),
    .i_thermistor_cooled(therm_cool), .o_balance_switch(sw),
    .o_die_sensor_enable(sens_en), .o_status(st));

  cell_bank_model cells (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_balance_switch(sw), .i_die_hot(die_hot),
    .i_therm_hot(therm_hot), .o_die_over(die_over), .o_die_below(die_below),
    .o_therm_over(therm_over), .o_therm_cooled(therm_cool));

  // 25 MHz clock
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : complete_run

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // Selects an observed output: switches, running or paused
  function automatic logic [15:0] probe(input int sel);
    case (sel)
      0: probe = sw;
      1: probe = {15'h0000, st.balance_running_flag};
      default: probe = {15'h0000, st.paused_flag};
    endcase
  endfunction : probe

  // Bounded wait; running out of cycles ends the run
  task automatic wait_for(input string what, input int sel, input logic [15:0] val,
                          input int bound);
    int n = 0;
    while (probe(sel) !== val && n < bound)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
    check(what, val, probe(sel));
    if (probe(sel) !== val)
      complete_run();
  endtask : wait_for

  // Loads timers (short channels get one unit) and pulses go for one cycle
  task automatic start(input logic [15:0] mask, input logic [15:0] short, input logic [7:0] tv);
    for (int k = 0; k < 16; k++)
      tmr[k] = short[k] ? 8'h01 : (mask[k] ? tv : 8'h00);
    @(posedge i_clk);
    #1;
    go = 1'b1;
    @(posedge i_clk);
    #1;
    go = 1'b0;
  endtask : start

  // Manual go with an expected accept or refuse
  task automatic manual(input logic [15:0] mask, input logic forbid, input logic ok);
    cfg.forbid_neighbor_switches = forbid;
    start(mask, 16'h0000, 8'hFF);
    repeat (2) @(posedge i_clk);
    #1;
    check("bad config", {15'h0000, ~ok}, {15'h0000, st.bad_config_flag});
    check("running", {15'h0000, ok}, {15'h0000, st.balance_running_flag});
    check("switches", ok ? mask : 16'h0000, sw);
  endtask : manual

  // Main sequence
  initial
  begin
    error_cnt = 0;
    compares = 0;
    i_rst_n = 1'b0;
    go = 1'b0;
    cfg = '{1'b0, 3'h0, 1'b0, 4'h0, 1'b0, 1'b0};
    tmr = '0;
    host_pause = 1'b0;
    fault = 1'b0;
    die_hot = 1'b0;
    therm_hot = 1'b0;
    repeat (8) @(posedge i_clk);
    #1;
    i_rst_n = 1'b1;
    check("reset switches", 16'h0000, sw);
    check("reset status", 16'h0000, {11'h000, st});

    start(16'h000B, 16'h0000, 8'hFF);
    wait_for("running", 1, 16'h0001, 3);
    check("early switches", 16'h0000, sw);
    check("die sensor enable", 16'h0001, {15'h0000, sens_en});
    wait_for("manual switches", 0, 16'h000B, 3);
    $display("test manual start done");

    manual(16'h2A5B, 1'b0, 1'b1);
    manual(16'hD555, 1'b0, 1'b0);
    manual(16'h0003, 1'b1, 1'b0);
    manual(16'h0003, 1'b0, 1'b1);
    manual(16'h0007, 1'b0, 1'b0);
    cfg.forbid_neighbor_switches = 1'b0;
    $display("test manual limits done");

    cfg.active_channel_count = 4'h2;
    start(16'h0005, 16'h0000, 8'hFF);
    wait_for("inactive channel", 0, 16'h0001, 4);
    cfg.active_channel_count = 4'h0;
    $display("test active count done");

    start(16'h0005, 16'h0001, 8'h03);
    wait_for("both on", 0, 16'h0005, 4);
    wait_for("one expired", 0, 16'h0004, 16);
    check("still running", 16'h0001, {15'h0000, st.balance_running_flag});
    wait_for("running cleared", 1, 16'h0000, 24);
    check("all off", 16'h0000, sw);
    $display("test timer expiry done");

    start(16'h0001, 16'h0000, 8'h03);
    wait_for("on before pause", 0, 16'h0001, 4);
    host_pause = 1'b1;
    wait_for("host pause", 2, 16'h0001, 3);
    repeat (40) @(posedge i_clk);
    #1;
    check("paused switches", 16'h0000, sw);
    host_pause = 1'b0;
    wait_for("unpaused", 2, 16'h0000, 3);
    wait_for("frozen timer resumes", 0, 16'h0001, 3);
    $display("test host pause done");

    start(16'h0001, 16'h0000, 8'hFF);
    wait_for("on before heat", 0, 16'h0001, 4);
    die_hot = 1'b1;
    wait_for("die pause", 2, 16'h0001, 8);
    check("die flag", 16'h0001, {15'h0000, st.overtemp_pause_flag});
    check("die switches", 16'h0000, sw);
    die_hot = 1'b0;
    wait_for("die release", 2, 16'h0000, 8);
    wait_for("die resume", 0, 16'h0001, 3);
    $display("test die pause done");

    // Thermistor pause is configured before go
    cfg.thermistor_pause_enable = 1'b1;
    start(16'h0001, 16'h0000, 8'hFF);
    wait_for("on before thermistor", 0, 16'h0001, 4);
    therm_hot = 1'b1;
    wait_for("thermistor pause", 2, 16'h0001, 4);
    check("thermistor flag", 16'h0001, {15'h0000, st.overtemp_pause_flag});
    therm_hot = 1'b0;
    wait_for("thermistor release", 2, 16'h0000, 4);
    wait_for("thermistor resume", 0, 16'h0001, 3);
    cfg.thermistor_pause_enable = 1'b0;
    $display("test thermistor pause done");

    cfg.fault_abort_enable = 1'b1;
    start(16'h0001, 16'h0000, 8'hFF);
    wait_for("on before fault", 0, 16'h0001, 4);
    fault = 1'b1;
    wait_for("abort", 1, 16'h0000, 3);
    check("abort flag", 16'h0001, {15'h0000, st.fault_abort_flag});
    check("abort switches", 16'h0000, sw);
    fault = 1'b0;
    cfg.fault_abort_enable = 1'b0;
    $display("test fault abort done");

    // Duty 1: each odd or even half lasts two timer units, eight cycles here
    cfg.auto_alternate_select = 1'b1;
    cfg.alternate_duty_field = 3'h1;
    start(16'h0003, 16'h0000, 8'hFF);
    wait_for("odd phase", 0, 16'h0001, 4);
    wait_for("even phase", 0, 16'h0002, 12);
    for (int c = 0; c < 8; c++)
    begin
      @(posedge i_clk);
      #1;
      check("duty half", (c < 7) ? 16'h0002 : 16'h0001, sw);
    end
    wait_for("odd again", 0, 16'h0001, 12);
    start(16'h0005, 16'h0000, 8'hFF);
    wait_for("odd only", 0, 16'h0005, 4);
    for (int c = 0; c < 16; c++)
    begin
      @(posedge i_clk);
      #1;
      check("no alternation", 16'h0005, sw);
    end
    $display("test auto mode done");

    complete_run();
  end
endmodule : passive_cell_balance_control_bench

//--- verilog/cell_balance_ctrl.sv
// Passive cell balancing controller for sixteen channels
//
// Behaviour
// - Balancing starts only on go; running flag shows balancing in progress
// - Channels beyond the active channel count are skipped despite timers
// - Each channel has a timer; nonzero marks it, switch waits for go
// - A timer reaching zero stops only its own channel
// - Automatic mode alternates odd and even switches using the duty field
// - Automatic mode with only odd or only even timers never alternates
// - Manual mode turns on every nonzero-timer switch, no alternation
// - Manual go with more than eight channels is refused, bad config set
// - Manual, forbid-neighbours set: any two adjacent channels are a bad config
// - Manual, forbid-neighbours clear: more than two consecutive channels are bad
// - Go enables die sensors; over-threshold pauses all, sets pause flags
// - Die pause ends once every sensor is below threshold minus hysteresis
// - Thermistor pause enabled and over threshold pauses all, sets flags
// - Thermistor pause ends once all thermistors read below recovery level
// - Pause freezes timers and settings; resume continues unchanged
// - New thermistor thresholds take effect via protector restart, no go
// - Balancing works in both active and sleep power states
// - Host pause request pauses balancing any time after start
// - Fault abort enabled plus unmasked fault in the run state stops all, sets abort flag; not acted on while paused
`timescale 1ns/10ps
module cell_balance_ctrl #(
  parameter int TICK_CYCLES = cell_balance_pkg::TIMER_UNIT_CYCLES,
  parameter int NUM_DIE_SENS = cell_balance_pkg::NUM_DIE_SENS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_balance_go_cmd,
  input wire cell_balance_pkg::bal_cfg_t i_cfg,
  input wire logic [cell_balance_pkg::NUM_CHAN-1:0][cell_balance_pkg::TIMER_W-1:0]
    i_channel_timer_setting,
  input wire logic i_host_pause_request,
  input wire logic i_unmasked_fault,
  input wire logic [NUM_DIE_SENS-1:0] i_die_over_threshold,
  input wire logic [NUM_DIE_SENS-1:0] i_die_below_release,
  input wire logic i_thermistor_overtemp_pause,
  input wire logic i_thermistor_cooled,
  output logic [cell_balance_pkg::NUM_CHAN-1:0] o_balance_switch,
  output logic o_die_sensor_enable,
  output cell_balance_pkg::bal_status_t o_status
);
  localparam int N = cell_balance_pkg::NUM_CHAN;
  localparam int TW = cell_balance_pkg::TIMER_W;

  // Number of set bits in a channel mask
  function automatic logic [4:0] count_ones(input logic [N-1:0] v);
    logic [4:0] n;
    n = 5'h00;
    for (int k = 0; k < N; k++)
      n = n + {4'h0, v[k]};
    return n;
  endfunction : count_ones

  // Longest run of consecutive set channels
  function automatic logic [4:0] longest_run(input logic [N-1:0] v);
    logic [4:0] run;
    logic [4:0] best;
    run = 5'h00;
    best = 5'h00;
    for (int k = 0; k < N; k++)
    begin
      run = v[k] ? run + 5'h01 : 5'h00;
      if (run > best)
        best = run;
    end
    return best;
  endfunction : longest_run

  // Channels inside the active count; zero means all sixteen
  function automatic logic [N-1:0] active_mask(input logic [3:0] cnt);
    logic [N-1:0] m;
    m = '0;
    for (int k = 0; k < N; k++)
      m[k] = (cnt == 4'h0) || (5'(k) < {1'b0, cnt});
    return m;
  endfunction : active_mask

  // Channels whose remaining time is nonzero
  function automatic logic [N-1:0] nonzero_mask(input logic [N-1:0][TW-1:0] t);
    logic [N-1:0] m;
    m = '0;
    for (int k = 0; k < N; k++)
      m[k] = (t[k] != '0);
    return m;
  endfunction : nonzero_mask

  cell_balance_pkg::bal_state_t state_r;
  cell_balance_pkg::bal_state_t state_nxt;
  logic [N-1:0][TW-1:0] remain_r;
  logic [N-1:0] switch_nxt;
  logic [N-1:0] go_mask;
  logic [N-1:0] left_mask;
  logic [N-1:0] odd_chan;
  logic [N-1:0] even_chan;
  logic go_bad;
  logic go_start;
  logic alt_r;
  logic phase_r;
  logic [2:0] phase_cnt_r;
  logic [2:0] duty_r;
  logic die_pause_r;
  logic therm_pause_r;
  logic pause_req;
  logic abort;
  logic tick;
  logic [NUM_DIE_SENS-1:0] die_over_s;
  logic [NUM_DIE_SENS-1:0] die_below_s;

  // Die comparators sit outside the clock domain
  level_sync3 #(.W(2 * NUM_DIE_SENS)) u_die_sync (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_async({i_die_over_threshold, i_die_below_release}),
    .o_level({die_over_s, die_below_s})
  );

  // Timer unit prescaler
  timer_tick #(.CYCLES(TICK_CYCLES)) u_tick (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .o_tick(tick)
  );

  // Channel 1 is bit 0, so odd channels are the even bit positions
  assign odd_chan = {(N / 2){2'b01}};
  assign even_chan = ~odd_chan;

  // Go evaluation: nonzero timers inside the active count
  always_comb
  begin
    go_mask = nonzero_mask(i_channel_timer_setting)
      & active_mask(i_cfg.active_channel_count);
    go_bad = 1'b0;
    if (!i_cfg.auto_alternate_select)
    begin
      if (count_ones(go_mask) > cell_balance_pkg::MAX_MANUAL_ON)
        go_bad = 1'b1;
      if (i_cfg.forbid_neighbor_switches
          && longest_run(go_mask) > cell_balance_pkg::MAX_RUN_ISOLATED)
        go_bad = 1'b1;
      if (!i_cfg.forbid_neighbor_switches
          && longest_run(go_mask) > cell_balance_pkg::MAX_RUN_NEIGHBORS)
        go_bad = 1'b1;
    end
    go_start = i_balance_go_cmd && !go_bad && (go_mask != '0);
  end

  // Pause and abort requests
  assign left_mask = nonzero_mask(remain_r);
  assign pause_req = die_pause_r || therm_pause_r || i_host_pause_request;
  assign abort = i_cfg.fault_abort_enable && i_unmasked_fault;

  // Sequencer; runs the same in every power state, nothing gates it
  always_comb
  begin
    state_nxt = state_r;
    if (i_balance_go_cmd)
      state_nxt = go_start ? cell_balance_pkg::ST_RUN : cell_balance_pkg::ST_IDLE;
    else
      unique case (state_r)
        cell_balance_pkg::ST_IDLE:
          state_nxt = cell_balance_pkg::ST_IDLE;
        cell_balance_pkg::ST_RUN:
          if (abort)
            state_nxt = cell_balance_pkg::ST_IDLE;
          else if (left_mask == '0)
            state_nxt = cell_balance_pkg::ST_IDLE;
          else if (pause_req)
            state_nxt = cell_balance_pkg::ST_PAUSE;
        cell_balance_pkg::ST_PAUSE:
          if (!pause_req)
            state_nxt = cell_balance_pkg::ST_RUN;
        default:
          state_nxt = cell_balance_pkg::ST_IDLE;
      endcase
  end

  // State register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      state_r <= cell_balance_pkg::ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // Per-channel countdown; frozen outside the run state
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      remain_r <= '0;
    else if (go_start)
    begin
      for (int k = 0; k < N; k++)
        remain_r[k] <= go_mask[k] ? i_channel_timer_setting[k]
                                  : cell_balance_pkg::TIMER_RST;
    end
    else if (state_r == cell_balance_pkg::ST_RUN && tick && !abort)
    begin
      for (int k = 0; k < N; k++)
        if (remain_r[k] != '0)
          remain_r[k] <= remain_r[k] - TW'(1);
    end
  end

  // Alternation mode and duty are latched at go and held through pauses
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      alt_r <= 1'b0;
      duty_r <= cell_balance_pkg::PHASE_RST;
    end
    else if (go_start)
    begin
      alt_r <= i_cfg.auto_alternate_select && |(go_mask & odd_chan)
        && |(go_mask & even_chan);
      duty_r <= i_cfg.alternate_duty_field;
    end
  end

  // Odd/even phase: each half lasts duty plus one timer units
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      phase_r <= 1'b0;
      phase_cnt_r <= cell_balance_pkg::PHASE_RST;
    end
    else if (go_start)
    begin
      phase_r <= 1'b0;
      phase_cnt_r <= cell_balance_pkg::PHASE_RST;
    end
    else if (state_r == cell_balance_pkg::ST_RUN && tick && alt_r)
    begin
      if (phase_cnt_r >= duty_r)
      begin
        phase_cnt_r <= cell_balance_pkg::PHASE_RST;
        phase_r <= !phase_r;
      end
      else
        phase_cnt_r <= phase_cnt_r + 3'h1;
    end
  end

  // Die pause latch: set above threshold, clear when all cool or when idle
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      die_pause_r <= 1'b0;
    else if (state_r != cell_balance_pkg::ST_IDLE && |die_over_s)
      die_pause_r <= 1'b1;
    else if (&die_below_s || state_r == cell_balance_pkg::ST_IDLE)
      die_pause_r <= 1'b0;
  end

  // Thermistor pause latch from the protector's judgement
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      therm_pause_r <= 1'b0;
    else if (state_r != cell_balance_pkg::ST_IDLE && i_cfg.thermistor_pause_enable
             && i_thermistor_overtemp_pause)
      therm_pause_r <= 1'b1;
    else if (i_thermistor_cooled || !i_cfg.thermistor_pause_enable
             || state_r == cell_balance_pkg::ST_IDLE)
      therm_pause_r <= 1'b0;
  end

  // Switch drive: off when paused or idle, skipping expired channels
  always_comb
  begin
    switch_nxt = cell_balance_pkg::SWITCH_RST;
    if (state_nxt == cell_balance_pkg::ST_RUN && !i_balance_go_cmd)
    begin
      switch_nxt = left_mask;
      if (alt_r)
        switch_nxt = left_mask & (phase_r ? even_chan : odd_chan);
    end
  end

  // Switch and sensor enable registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_balance_switch <= cell_balance_pkg::SWITCH_RST;
      o_die_sensor_enable <= 1'b0;
    end
    else
    begin
      o_balance_switch <= switch_nxt;
      o_die_sensor_enable <= (state_nxt != cell_balance_pkg::ST_IDLE);
    end
  end

  // Status flags; sticky ones clear on go, but a same-cycle set wins
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_status <= cell_balance_pkg::STATUS_RST;
    else
    begin
      o_status.balance_running_flag <= (state_nxt != cell_balance_pkg::ST_IDLE);
      o_status.paused_flag <= (state_nxt == cell_balance_pkg::ST_PAUSE);
      if (state_r != cell_balance_pkg::ST_IDLE
          && (|die_over_s || (i_cfg.thermistor_pause_enable
          && i_thermistor_overtemp_pause)))
        o_status.overtemp_pause_flag <= 1'b1;
      else if (i_balance_go_cmd)
        o_status.overtemp_pause_flag <= 1'b0;
      if (i_balance_go_cmd)
        o_status.bad_config_flag <= go_bad;
      if (state_r == cell_balance_pkg::ST_RUN && abort)
        o_status.fault_abort_flag <= 1'b1;
      else if (i_balance_go_cmd)
        o_status.fault_abort_flag <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);

  a_go_starts_run: assert property (go_start |=> (o_status.balance_running_flag
    && o_balance_switch == '0) ##1 (o_balance_switch != '0 || $past(pause_req)
    || $past(abort) || $past(i_balance_go_cmd)))
    else $error("valid go did not start balancing");
  a_skip_inactive: assert property (go_start |=>
    (left_mask & ~active_mask($past(i_cfg.active_channel_count))) == '0)
    else $error("channel outside active count loaded");
  a_go_holds_off: assert property (i_balance_go_cmd |=> o_balance_switch == '0)
    else $error("switch on right after go");
  a_manual_refuse: assert property (i_balance_go_cmd && !i_cfg.auto_alternate_select
    && count_ones(go_mask) > cell_balance_pkg::MAX_MANUAL_ON
    |=> o_status.bad_config_flag && !o_status.balance_running_flag)
    else $error("more than eight channels not refused");
  a_neighbor_refuse: assert property (i_balance_go_cmd && !i_cfg.auto_alternate_select
    && i_cfg.forbid_neighbor_switches
    && longest_run(go_mask) > cell_balance_pkg::MAX_RUN_ISOLATED |=> o_status.bad_config_flag)
    else $error("adjacent channels not refused");
  a_pause_off: assert property (o_status.paused_flag |-> o_balance_switch == '0)
    else $error("switch on while paused");
  a_pause_freeze: assert property (state_r == cell_balance_pkg::ST_PAUSE
    && !i_balance_go_cmd |=> $stable(remain_r))
    else $error("timers moved during pause");
  a_host_pause: assert property (state_r == cell_balance_pkg::ST_RUN
    && i_host_pause_request && !i_balance_go_cmd && !abort && left_mask != '0
    |=> o_status.paused_flag ##1 (o_status.paused_flag || !$past(pause_req)
    || $past(i_balance_go_cmd)))
    else $error("host pause not honoured");
  a_fault_stop: assert property (state_r == cell_balance_pkg::ST_RUN && abort
    && !i_balance_go_cmd |=> o_status.fault_abort_flag && !o_status.balance_running_flag
    && o_balance_switch == '0)
    else $error("fault abort did not stop balancing");
  a_manual_all_on: assert property (state_r == cell_balance_pkg::ST_RUN && !alt_r
    && state_nxt == cell_balance_pkg::ST_RUN && !i_balance_go_cmd
    |=> o_balance_switch == $past(left_mask))
    else $error("manual switch set differs from nonzero timers");
  a_done_clears: assert property (state_r == cell_balance_pkg::ST_RUN && left_mask == '0
    && !i_balance_go_cmd |=> !o_status.balance_running_flag)
    else $error("running flag stuck after all channels done");
endmodule : cell_balance_ctrl

//--- verilog/level_sync3.sv
// Three-stage synchroniser that passes a change once stages two and three agree
`timescale 1ns/10ps
module level_sync3 #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  // Shift chain; only s2_r reads s1_r
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end
    else
    begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // Accept a bit only when the two later stages agree
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_level <= '0;
    else
      for (int k = 0; k < W; k++)
        if (s2_r[k] == s3_r[k])
          o_level[k] <= s3_r[k];
  end
endmodule : level_sync3

//--- verilog/timer_tick.sv
// Free-running prescaler giving one pulse per balancing timer unit
`timescale 1ns/10ps
module timer_tick #(
  parameter int CYCLES = cell_balance_pkg::TIMER_UNIT_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_tick
);
  logic [31:0] cnt_r;

  // Count up to CYCLES-1 then wrap with a one-cycle pulse
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_r <= 32'h0000_0000;
      o_tick <= 1'b0;
    end
    else if (cnt_r >= 32'(CYCLES - 1))
    begin
      cnt_r <= 32'h0000_0000;
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 32'h0000_0001;
      o_tick <= 1'b0;
    end
  end
endmodule : timer_tick
